// ---- power_monitor_cfg.svh ----
// Register map, field positions, reset values and timing figures of the power monitor sequencer
`ifndef POWER_MONITOR_CFG_SVH
`define POWER_MONITOR_CFG_SVH

// ==========================================================================
// Register addresses
`define REG_ADDR_W 6
`define ADDR_CONVERTER_CFG 6'h01
`define ADDR_BUS_VOLTAGE 6'h05
`define ADDR_DIE_TEMP 6'h06
`define ADDR_CURRENT 6'h07
`define ADDR_POWER 6'h08

// ==========================================================================
// Converter configuration fields and reset
`define CFG_RESET 16'hFB68
`define CFG_MODE_MSB 15
`define CFG_MODE_LSB 12
`define CFG_BUS_CT_MSB 11
`define CFG_BUS_CT_LSB 9
`define CFG_SHUNT_CT_MSB 8
`define CFG_SHUNT_CT_LSB 6
`define CFG_TEMP_CT_MSB 5
`define CFG_TEMP_CT_LSB 3
`define CFG_AVG_MSB 2
`define CFG_AVG_LSB 0

// ==========================================================================
// Result layout
`define TEMP_PAD_BITS 4
`define POWER_SHIFT 6
`define ACC_W 27

// ==========================================================================
// Timing
`define MCLK_MHZ 100
`define DELAY_STEP_MS 2
`define CT_US_0 50
`define CT_US_1 84
`define CT_US_2 150
`define CT_US_3 280
`define CT_US_4 540
`define CT_US_5 1052
`define CT_US_6 2074
`define CT_US_7 4120

`endif

// ---- power_monitor_pkg.sv ----
// Types shared by the power monitor sequencer and its users
package power_monitor_pkg;

  // ==========================================================================
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // ==========================================================================
  // Raw samples from the measurement front end
  typedef struct packed {
    logic [15:0] bus;
    logic [15:0] current;
    logic [11:0] temp;
  } sample_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DELAY = 4'h2,
    ST_CONV = 4'h4,
    ST_UPDATE = 4'h8
  } seq_state_t;

  typedef enum logic [1:0] {
    CH_TEMP = 2'h0,
    CH_CURRENT = 2'h1,
    CH_BUS = 2'h2,
    CH_NONE = 2'h3
  } chan_t;

  typedef struct packed {
    logic continuous;
    logic active;
    logic [2:0] en;
  } mode_dec_t;

endpackage : power_monitor_pkg

// ---- power_monitor_adc_sequencer.sv ----
// Measurement sequencer, averaging and result registers of the power monitor
// Function
// RULE1: Mode field bits 15-12, resets all ones
// RULE2: Codes 0h/8h shutdown; 1h single bus conversion
// RULE3: Codes 4h-7h single temperature-based passes
// RULE4: Codes 9h, Ch-Fh convert continuously
// RULE5: Bus conversion time field, eight steps
// RULE6: Shunt conversion time field, same encoding
// RULE7: Temperature conversion time field, same encoding
// RULE8: Current takes shunt plus temperature time
// RULE9: Averaging field sets sample count 1-1024
// RULE10: Results update only after full averaging
// RULE11: Bus voltage result, never negative
// RULE12: Temperature in bits 15-4, low zero
// RULE13: Current result 16-bit two's complement
// RULE14: Power result 24-bit unsigned
// RULE15: Initial conversion delay in 2 ms steps
// RULE16: Host avoids reserved mode codes
// RULE17: Writes to result registers ignored
`timescale 1ns/1ps
`include "power_monitor_cfg.svh"

module power_monitor_adc_sequencer import power_monitor_pkg::*; #(
  parameter int CYCLES_PER_US = `MCLK_MHZ,
  parameter int DELAY_STEP_CYCLES = `DELAY_STEP_MS * 1000 * `MCLK_MHZ
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire reg_req_t reg_req,
  output logic [23:0] reg_rdata,
  input wire logic [7:0] initial_conversion_delay,
  input wire sample_t sample,
  output chan_t adc_chan,
  output logic adc_busy
);

  // ==========================================================================
  // Helpers
  function automatic mode_dec_t decode_mode(input logic [3:0] m);
    mode_dec_t d;
    d = '0;
    // Reserved codes fall to shutdown
    unique case (m)
      4'h1: d = '{1'b0, 1'b1, 3'h4}; // RULE2
      4'h4: d = '{1'b0, 1'b1, 3'h1}; // RULE3
      4'h5: d = '{1'b0, 1'b1, 3'h5}; // RULE3
      4'h6: d = '{1'b0, 1'b1, 3'h3}; // RULE3
      4'h7: d = '{1'b0, 1'b1, 3'h7}; // RULE3
      4'h9: d = '{1'b1, 1'b1, 3'h4}; // RULE4
      4'hC: d = '{1'b1, 1'b1, 3'h1}; // RULE4
      4'hD: d = '{1'b1, 1'b1, 3'h5}; // RULE4
      4'hE: d = '{1'b1, 1'b1, 3'h3}; // RULE4
      4'hF: d = '{1'b1, 1'b1, 3'h7}; // RULE4
      default: d = '0; // RULE2 RULE16
    endcase
    return d;
  endfunction : decode_mode

  function automatic logic [31:0] conv_cycles(input logic [2:0] ct);
    int us;
    us = `CT_US_0;
    unique case (ct)
      3'h0: us = `CT_US_0;
      3'h1: us = `CT_US_1;
      3'h2: us = `CT_US_2;
      3'h3: us = `CT_US_3;
      3'h4: us = `CT_US_4;
      3'h5: us = `CT_US_5;
      3'h6: us = `CT_US_6;
      3'h7: us = `CT_US_7;
    endcase
    return 32'(us * CYCLES_PER_US); // RULE5 RULE6 RULE7
  endfunction : conv_cycles

  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    logic [3:0] s;
    s = 4'h0;
    unique case (code)
      3'h0: s = 4'h0;
      3'h1: s = 4'h2;
      3'h2: s = 4'h4;
      3'h3: s = 4'h6;
      3'h4: s = 4'h7;
      3'h5: s = 4'h8;
      3'h6: s = 4'h9;
      3'h7: s = 4'hA;
    endcase
    return s; // RULE9
  endfunction : avg_shift

  function automatic chan_t next_chan(input logic [2:0] en, input logic [2:0] from);
    chan_t c;
    c = CH_NONE;
    for (int i = 2; i >= 0; i--) begin
      if (en[i] && 3'(i) >= from) begin
        c = chan_t'(2'(i));
      end
    end
    return c;
  endfunction : next_chan

  // ==========================================================================
  // Configuration register
  logic [15:0] cfg_r;
  logic cfg_wr;
  mode_dec_t md;
  logic [2:0] bus_ct;
  logic [2:0] shunt_ct;
  logic [2:0] temp_ct;
  logic [3:0] shift;
  logic [9:0] last_round;

  assign cfg_wr = reg_req.wr && reg_req.addr == `ADDR_CONVERTER_CFG;
  assign md = decode_mode(cfg_r[`CFG_MODE_MSB:`CFG_MODE_LSB]);
  assign bus_ct = cfg_r[`CFG_BUS_CT_MSB:`CFG_BUS_CT_LSB];
  assign shunt_ct = cfg_r[`CFG_SHUNT_CT_MSB:`CFG_SHUNT_CT_LSB];
  assign temp_ct = cfg_r[`CFG_TEMP_CT_MSB:`CFG_TEMP_CT_LSB];
  assign shift = avg_shift(cfg_r[`CFG_AVG_MSB:`CFG_AVG_LSB]);
  assign last_round = 10'((11'h001 << shift) - 11'h001);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `CFG_RESET; // RULE1
    end else if (cfg_wr) begin
      cfg_r <= reg_req.wdata; // RULE1
    end
  end

  function automatic logic [31:0] chan_cycles(input chan_t c);
    logic [31:0] n;
    n = conv_cycles(bus_ct); // RULE5
    if (c == CH_TEMP) begin
      n = conv_cycles(temp_ct); // RULE7
    end else if (c == CH_CURRENT) begin
      n = conv_cycles(shunt_ct) + conv_cycles(temp_ct); // RULE6 RULE8
    end
    return n - 32'h1;
  endfunction : chan_cycles

  // ==========================================================================
  // Sequencer
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [31:0] timer_r;
  logic [31:0] timer_nxt;
  chan_t ch_r;
  chan_t ch_nxt;
  logic [9:0] round_r;
  logic [9:0] round_nxt;
  logic pend_r;
  logic pend_nxt;
  logic acc_clr;
  logic acc_take;
  chan_t first_ch;
  chan_t after_ch;
  mode_dec_t wr_md;

  assign wr_md = decode_mode(reg_req.wdata[`CFG_MODE_MSB:`CFG_MODE_LSB]);
  assign first_ch = next_chan(md.en, 3'h0);
  assign after_ch = next_chan(md.en, 3'(ch_r) + 3'h1);

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    ch_nxt = ch_r;
    round_nxt = round_r;
    pend_nxt = pend_r;
    acc_clr = 1'b0;
    acc_take = 1'b0;
    if (cfg_wr) begin
      // A write aborts any pass; a triggered code arms one new pass
      state_nxt = ST_IDLE;
      ch_nxt = CH_NONE;
      pend_nxt = wr_md.active;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (pend_r && md.active) begin
            state_nxt = ST_DELAY;
            timer_nxt = 32'(initial_conversion_delay) * 32'(DELAY_STEP_CYCLES); // RULE15
            pend_nxt = 1'b0;
          end
        end
        ST_DELAY: begin
          if (timer_r == 32'h0) begin
            state_nxt = ST_CONV;
            ch_nxt = first_ch;
            timer_nxt = chan_cycles(first_ch);
            round_nxt = 10'h000;
            acc_clr = 1'b1;
          end else begin
            timer_nxt = timer_r - 32'h1; // RULE15
          end
        end
        ST_CONV: begin
          if (timer_r == 32'h0) begin
            acc_take = 1'b1;
            if (after_ch != CH_NONE) begin
              ch_nxt = after_ch;
              timer_nxt = chan_cycles(after_ch);
            end else if (round_r == last_round) begin
              state_nxt = ST_UPDATE; // RULE10
              ch_nxt = CH_NONE;
            end else begin
              round_nxt = round_r + 10'h001; // RULE9
              ch_nxt = first_ch;
              timer_nxt = chan_cycles(first_ch);
            end
          end else begin
            timer_nxt = timer_r - 32'h1;
          end
        end
        ST_UPDATE: begin
          if (md.continuous) begin
            state_nxt = ST_CONV; // RULE4
            ch_nxt = first_ch;
            timer_nxt = chan_cycles(first_ch);
            round_nxt = 10'h000;
            acc_clr = 1'b1;
          end else begin
            state_nxt = ST_IDLE; // RULE2 RULE3
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      timer_r <= 32'h0;
      ch_r <= CH_NONE;
      round_r <= 10'h000;
      // Reset mode is continuous, so the first pass is armed
      pend_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      ch_r <= ch_nxt;
      round_r <= round_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ==========================================================================
  // Averaging accumulators
  logic signed [`ACC_W-1:0] acc_r [3];
  logic signed [`ACC_W-1:0] smp_ext;

  always_comb begin
    smp_ext = `ACC_W'(signed'(sample.bus));
    if (ch_r == CH_TEMP) begin
      smp_ext = `ACC_W'(signed'(sample.temp));
    end else if (ch_r == CH_CURRENT) begin
      smp_ext = `ACC_W'(signed'(sample.current));
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        acc_r[i] <= '0;
      end
    end else if (acc_clr) begin
      for (int i = 0; i < 3; i++) begin
        acc_r[i] <= '0;
      end
    end else if (acc_take) begin
      acc_r[ch_r] <= acc_r[ch_r] + smp_ext; // RULE9
    end
  end

  // ==========================================================================
  // Result registers
  logic [15:0] bus_res_r;
  logic [11:0] temp_res_r;
  logic [15:0] cur_res_r;
  logic [23:0] pwr_res_r;
  logic signed [`ACC_W-1:0] bus_avg;
  logic signed [`ACC_W-1:0] temp_avg;
  logic signed [`ACC_W-1:0] cur_avg;
  logic [15:0] bus_new;
  logic [15:0] cur_new;
  logic [16:0] cur_mag;
  logic [32:0] pwr_prod;
  logic [26:0] pwr_scaled;
  logic upd;

  assign upd = state_r == ST_UPDATE;
  assign bus_avg = acc_r[CH_BUS] >>> shift;
  assign temp_avg = acc_r[CH_TEMP] >>> shift;
  assign cur_avg = acc_r[CH_CURRENT] >>> shift;
  // Negative offsets near 0 V would otherwise read as huge voltages
  assign bus_new = !md.en[CH_BUS] ? bus_res_r : bus_avg[`ACC_W-1] ? 16'h0000 : bus_avg[15:0]; // RULE11
  assign cur_new = md.en[CH_CURRENT] ? cur_avg[15:0] : cur_res_r; // RULE13
  assign cur_mag = cur_new[15] ? 17'(~{1'b1, cur_new} + 17'h00001) : {1'b0, cur_new};
  assign pwr_prod = 33'(bus_new) * 33'(cur_mag);
  assign pwr_scaled = pwr_prod[32:`POWER_SHIFT];

  // Results move only here, once the whole averaging pass is done
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_res_r <= 16'h0000;
      temp_res_r <= 12'h000;
      cur_res_r <= 16'h0000;
      pwr_res_r <= 24'h000000;
    end else if (upd) begin
      bus_res_r <= bus_new; // RULE10 RULE11
      cur_res_r <= cur_new; // RULE13
      if (md.en[CH_TEMP]) begin
        temp_res_r <= temp_avg[11:0]; // RULE12
      end
      if (md.en[CH_BUS] || md.en[CH_CURRENT]) begin
        // Saturate rather than wrap on overrange
        pwr_res_r <= |pwr_scaled[26:24] ? 24'hFFFFFF : pwr_scaled[23:0]; // RULE14
      end
    end
  end

  // ==========================================================================
  // Read port and status outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 24'h000000;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        `ADDR_CONVERTER_CFG: reg_rdata <= {8'h00, cfg_r};
        `ADDR_BUS_VOLTAGE: reg_rdata <= {8'h00, bus_res_r};
        `ADDR_DIE_TEMP: reg_rdata <= {8'h00, temp_res_r, `TEMP_PAD_BITS'h0}; // RULE12
        `ADDR_CURRENT: reg_rdata <= {8'h00, cur_res_r};
        `ADDR_POWER: reg_rdata <= pwr_res_r;
        default: reg_rdata <= 24'h000000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      adc_chan <= CH_NONE;
      adc_busy <= 1'b0;
    end else begin
      adc_chan <= ch_nxt;
      adc_busy <= state_nxt != ST_IDLE;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_cfg_write_lands: assert property (cfg_wr |=> cfg_r == $past(reg_req.wdata)) // RULE1
    else $error("config write not stored");
  a_shutdown_stays: assert property ((state_r == ST_IDLE && !md.active && !cfg_wr) |=> state_r == ST_IDLE) // RULE2
    else $error("shutdown mode left idle");
  a_single_stops: assert property ((upd && !md.continuous && !cfg_wr) |=> state_r == ST_IDLE) // RULE3
    else $error("single shot did not stop");
  a_cont_restarts: assert property ((upd && md.continuous && !cfg_wr) |=> state_r == ST_CONV && round_r == 10'h000) // RULE4
    else $error("continuous mode did not restart");
  a_cur_time_sum: assert property ((state_r == ST_CONV && timer_r == 32'h0 && after_ch == CH_CURRENT && !cfg_wr)
      |=> timer_r == conv_cycles(shunt_ct) + conv_cycles(temp_ct) - 32'h1) // RULE8
    else $error("current conversion time wrong");
  a_avg_rounds: assert property ((state_r == ST_CONV) ##1 upd |-> $past(round_r) == last_round) // RULE9
    else $error("averaging round count wrong");
  a_result_hold: assert property (!upd |=> $stable(bus_res_r) && $stable(cur_res_r) && $stable(pwr_res_r)) // RULE10
    else $error("result moved outside update");
  a_bus_positive: assert property (!bus_res_r[15]) // RULE11
    else $error("bus voltage result negative");
  a_temp_pad_zero: assert property ((reg_req.rd && reg_req.addr == `ADDR_DIE_TEMP) |=> reg_rdata[3:0] == 4'h0) // RULE12
    else $error("temperature low bits not zero");
  a_delay_count: assert property ((state_r == ST_IDLE && state_nxt == ST_DELAY)
      |=> timer_r == 32'($past(initial_conversion_delay)) * 32'(DELAY_STEP_CYCLES)) // RULE15
    else $error("initial delay count wrong");
  a_ro_ignored: assert property ((reg_req.wr && reg_req.addr == `ADDR_BUS_VOLTAGE && !upd) |=> $stable(bus_res_r)) // RULE17
    else $error("result register took a write");

  c_single_pass: cover property (upd && !md.continuous);
  c_cont_pass: cover property (upd && md.continuous && md.en == 3'h7);
  c_avg_pass: cover property (upd && shift != 4'h0);
  c_abort: cover property (cfg_wr && state_r == ST_CONV);

endmodule : power_monitor_adc_sequencer

// ---- front_end_model.sv ----
// Measurement front end that hands the sequencer one raw sample per channel
`timescale 1ns/1ps

module front_end_model import power_monitor_pkg::*; (
  input wire chan_t adc_chan,
  input wire logic [15:0] bus_in,
  input wire logic [15:0] cur_in,
  input wire logic [11:0] tmp_in,
  output sample_t sample
);
  // ==========================================================================
  // Sample drive
  // Unselected fields carry the inverse so a wrong channel pick shows
  always_comb begin
    sample.bus = (adc_chan == CH_BUS) ? bus_in : ~bus_in;
    sample.current = (adc_chan == CH_CURRENT) ? cur_in : ~cur_in;
    sample.temp = (adc_chan == CH_TEMP) ? tmp_in : ~tmp_in;
  end
endmodule : front_end_model

// ---- power_monitor_adc_sequencer_bench.sv ----
// Self-checking bench for the power monitor sequencer
`timescale 1ns/1ps
`include "power_monitor_cfg.svh"

module power_monitor_adc_sequencer_bench import power_monitor_pkg::*; ;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t reg_req = '0;
  logic [23:0] reg_rdata;
  logic [7:0] dly_code = 8'h00;
  sample_t sample;
  chan_t adc_chan;
  logic adc_busy;
  logic [15:0] bus_in = 16'h0000;
  logic [15:0] cur_in = 16'h0000;
  logic [11:0] tmp_in = 12'h000;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  int modes[9] = '{1, 4, 5, 6, 7, 1, 1, 1, 1};
  int avgs[9] = '{0, 0, 0, 0, 0, 1, 2, 3, 5};
  int dlys[9] = '{0, 3, 0, 0, 0, 0, 0, 1, 0};
  int rnds[8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
  int conts[5] = '{9, 12, 13, 14, 15};

  always #5 mclk = ~mclk;

  power_monitor_adc_sequencer #(.CYCLES_PER_US(1), .DELAY_STEP_CYCLES(10)) power_monitor_adc_sequencer_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .initial_conversion_delay(dly_code),
    .sample(sample),
    .adc_chan(adc_chan),
    .adc_busy(adc_busy)
  );

  front_end_model front_end_model_inst (
    .adc_chan(adc_chan),
    .bus_in(bus_in),
    .cur_in(cur_in),
    .tmp_in(tmp_in),
    .sample(sample)
  );

  // ==========================================================================
  // Access and compare tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_dur(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_dur

  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_req <= {1'b1, 1'b0, a, d};
    @(posedge mclk);
    reg_req <= '0;
  endtask : wr_reg

  task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
    @(posedge mclk);
    reg_req <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge mclk);
    reg_req <= '0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd_chk

  // Busy cycles of one pass; bounded so a stuck sequencer cannot hang
  task automatic wait_idle(output int cnt);
    cnt = 0;
    for (int i = 0; i < 60000; i++) begin
      @(posedge mclk);
      #1;
      if (adc_busy === 1'b1) cnt++;
      else if (cnt > 0) break;
    end
  endtask : wait_idle

  function automatic int conv_time(input int m);
    conv_time = 0;
    if (m >= 4) conv_time += `CT_US_2;
    if (m >= 6) conv_time += `CT_US_0 + `CT_US_2;
    if (m == 1 || m == 5 || m == 7) conv_time += `CT_US_1;
  endfunction : conv_time

  task automatic complete_run;
    $display("Errors %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Tests
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(`ADDR_CONVERTER_CFG, 24'h00FB68);
    for (int a = 5; a <= 8; a++) rd_chk(a[5:0], 24'h000000);
    rd_chk(6'h02, 24'h000000);
    wr_reg(`ADDR_CONVERTER_CFG, 16'h0210);
    // Pass length: delay, rounds of enabled channels, one update cycle
    for (int k = 0; k < 9; k++) begin
      @(posedge mclk);
      dly_code <= dlys[k][7:0];
      wr_reg(`ADDR_CONVERTER_CFG, 16'(modes[k] << 12) | 16'h0210 | 16'(avgs[k]));
      wait_idle(n);
      chk_dur(n, dlys[k] * 10 + 2 + rnds[avgs[k]] * conv_time(modes[k]));
    end
    // Other time codes on every field, and a 128-sample averaging run on temperature alone
    wr_reg(`ADDR_CONVERTER_CFG, 16'h7700);
    wait_idle(n);
    chk_dur(n, 2 + `CT_US_0 + `CT_US_4 + `CT_US_0 + `CT_US_3);
    wr_reg(`ADDR_CONVERTER_CFG, 16'h7FA8);
    wait_idle(n);
    chk_dur(n, 2 + `CT_US_5 + `CT_US_6 + `CT_US_5 + `CT_US_7);
    wr_reg(`ADDR_CONVERTER_CFG, 16'h4004);
    wait_idle(n);
    chk_dur(n, 2 + 128 * `CT_US_0);
    @(posedge mclk);
    dly_code <= 8'h00;
    bus_in <= 16'h1234;
    cur_in <= 16'hFF00;
    tmp_in <= 12'hF38;
    wr_reg(`ADDR_CONVERTER_CFG, 16'h7210);
    wait_idle(n);
    rd_chk(`ADDR_BUS_VOLTAGE, 24'h001234);
    rd_chk(`ADDR_DIE_TEMP, 24'h00F380);
    rd_chk(`ADDR_CURRENT, 24'h00FF00);
    rd_chk(`ADDR_POWER, 24'h0048D0);
    for (int a = 5; a <= 8; a++) wr_reg(a[5:0], 16'hFFFF);
    rd_chk(`ADDR_BUS_VOLTAGE, 24'h001234);
    rd_chk(`ADDR_CURRENT, 24'h00FF00);
    rd_chk(`ADDR_POWER, 24'h0048D0);
    bus_in <= 16'h8005;
    wr_reg(`ADDR_CONVERTER_CFG, 16'h1210);
    wait_idle(n);
    rd_chk(`ADDR_BUS_VOLTAGE, 24'h000000);
    rd_chk(`ADDR_DIE_TEMP, 24'h00F380);
    bus_in <= 16'h0100;
    wr_reg(`ADDR_CONVERTER_CFG, 16'h1211);
    repeat (150) @(posedge mclk);
    rd_chk(`ADDR_BUS_VOLTAGE, 24'h000000);
    chk({22'h0, adc_chan}, 24'h000002);
    wait_idle(n);
    rd_chk(`ADDR_BUS_VOLTAGE, 24'h000100);
    // Continuous codes must still run long after one pass would end
    for (int k = 0; k < 5; k++) begin
      wr_reg(`ADDR_CONVERTER_CFG, 16'(conts[k] << 12) | 16'h0210);
      repeat (1000) @(posedge mclk);
      #1;
      chk({23'h0, adc_busy}, 24'h000001);
      wr_reg(`ADDR_CONVERTER_CFG, (k % 2 == 0) ? 16'h0210 : 16'h8210);
      repeat (5) @(posedge mclk);
      #1;
      chk({23'h0, adc_busy}, 24'h000000);
      chk({22'h0, adc_chan}, 24'h000003);
    end
    complete_run();
  end

  initial begin
    #900000;
    num_errors++;
    complete_run();
  end
endmodule : power_monitor_adc_sequencer_bench
